// file: shared/remap_pkg.sv
// address map, carrier types and defaults for the boot-remap address decoder
// assumes a 32-bit byte address bus and one decoder per bus master
package remap_pkg;

  // ************************************************************
  // masters and address split
  // ************************************************************
  localparam int          NUM_MASTERS     = 4;
  localparam int          MASTER_CPU_INSTR = 0;
  localparam int          MASTER_CPU_DATA  = 1;
  localparam int          ADDR_W          = 32;
  localparam int          NUM_CHIP_SEL    = 8;

  // sixteen banks of 256 Mbyte picked by the top four address bits
  localparam logic [3:0]  BANK_INTERNAL   = 4'h0;
  localparam logic [3:0]  BANK_EXT_FIRST  = 4'h1;
  localparam logic [3:0]  BANK_EXT_LAST   = 4'h7;
  localparam logic [3:0]  BANK_PERIPH     = 4'hF;

  // second level inside bank zero: 1 Mbyte slots picked by bits 27:20
  localparam logic [7:0]  SLOT_BOOT       = 8'h00;
  localparam logic [7:0]  SLOT_ROM        = 8'h01;
  localparam logic [7:0]  SLOT_FIRST_INTERNAL_SRAM      = 8'h02;
  localparam logic [7:0]  SLOT_SRAM1      = 8'h03;

  // sizes of the embedded memories, as offsets inside a slot, then the boot window top and ROM base addresses
  localparam logic [19:0] ROM_BYTES       = 20'h08000;
  localparam logic [19:0] SRAM_BYTES      = 20'h01000;
  localparam logic [31:0] BOOT_WINDOW_TOP = 32'h000F_FFFF;
  localparam logic [31:0] ROM_BASE        = 32'h0010_0000;

  // static memory defaults when booting from external chip select zero
  localparam logic [1:0]  WIDTH_8         = 2'h0;
  localparam logic [1:0]  WIDTH_16        = 2'h1;
  localparam logic [1:0]  WIDTH_32        = 2'h2;
  localparam logic        BOOT_BYTE_SEL   = 1'b1;
  localparam logic        BOOT_STROBE_CS  = 1'b1;

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [2:0] {
    SLV_NONE, SLV_ROM, SLV_FIRST_INTERNAL_SRAM, SLV_SRAM1, SLV_EXT, SLV_PERIPH
  } slave_t;

  typedef struct packed {
    logic              valid;
    logic              write;
    logic [ADDR_W-1:0] addr;
  } bus_req_t;

  typedef struct packed {
    logic        valid;
    logic        abort;
    slave_t      slave;
    logic [2:0]  chip_sel;
    logic [27:0] offset;
  } route_t;

  typedef struct packed {
    logic       byte_select;
    logic [1:0] data_width;
    logic       strobe_by_cs;
  } smc_cfg_t;

endpackage : remap_pkg

// file: hw/boot_strap_capture.sv
// boot-select strap synchroniser and capture
// assumes reset is held low for at least three clock edges
`timescale 1ns/1ps
module boot_strap_capture
  import remap_pkg::*;
(
  // clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // strap pin and captured level
  input  wire logic boot_source_pin,
  output logic      boot_from_rom
);

  logic sync_first;
  logic sync_second;

  // two-stage synchroniser, free running so it is settled before release
  always_ff @(posedge clock) begin
    sync_first  <= boot_source_pin;
    sync_second <= sync_first;
  end

  // track the strap while in reset, freeze it from release onward
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      boot_from_rom <= sync_second;
    end
  end

endmodule : boot_strap_capture

// file: hw/bank_decoder.sv
// combinational address decoder for one bus master
// assumes the strap and remap levels are already in the clock domain
`timescale 1ns/1ps
module bank_decoder
  import remap_pkg::*;
#(
  parameter bit REMAP_CAPABLE = 1'b0
) (
  // request and map controls
  input  bus_req_t  req,
  input  wire logic boot_from_rom,
  input  wire logic remap,
  // decoded route
  output route_t    route
);

  logic [3:0]  bank;
  logic [7:0]  slot;
  logic [19:0] low;

  assign bank = req.addr[31:28];
  assign slot = req.addr[27:20];
  assign low  = req.addr[19:0];

  // unmatched areas fall through to an abort
  always_comb begin
    route          = '0;
    route.valid    = req.valid;
    route.abort    = req.valid;
    route.slave    = SLV_NONE;
    route.offset   = {8'h00, low};
    if (bank == BANK_INTERNAL) begin
      case (slot)
        SLOT_BOOT: begin
          // only the processor masters see a boot memory at zero
          if (REMAP_CAPABLE) begin
            if (remap) begin
              if (low < SRAM_BYTES) route.slave = SLV_FIRST_INTERNAL_SRAM;
            end else if (boot_from_rom) begin
              if (low < ROM_BYTES) route.slave = SLV_ROM;
            end else begin
              route.slave = SLV_EXT;
            end
          end
        end
        SLOT_ROM: begin
          if (low < ROM_BYTES) route.slave = SLV_ROM;
        end
        SLOT_FIRST_INTERNAL_SRAM: begin
          if (low < SRAM_BYTES) route.slave = SLV_FIRST_INTERNAL_SRAM;
        end
        SLOT_SRAM1: begin
          if (low < SRAM_BYTES) route.slave = SLV_SRAM1;
        end
        default: route.slave = SLV_NONE;
      endcase
    end else if (bank >= BANK_EXT_FIRST && bank <= BANK_EXT_LAST) begin
      route.slave    = SLV_EXT;
      route.chip_sel = bank[2:0];
      route.offset   = req.addr[27:0];
    end else if (bank == BANK_PERIPH) begin
      route.slave  = SLV_PERIPH;
      route.offset = req.addr[27:0];
    end
    if (route.slave != SLV_NONE) begin
      route.abort = 1'b0;
    end
  end

endmodule : bank_decoder

// file: hw/boot_remap_address_decoder.sv
// first-level bus matrix address decoder with boot memory selection
// assumes each master holds one request per cycle and reads the route
// one cycle later; remap set and clear come from same-clock logic
`timescale 1ns/1ps
module boot_remap_address_decoder
  import remap_pkg::*;
(
  // clock and reset
  input  wire logic                   clock,
  input  wire logic                   rst_n,
  // strap pin and remap control
  input  wire logic                   boot_source_pin,
  input  wire logic                   remap_set,
  input  wire logic                   remap_clear,
  // master requests
  input  bus_req_t                    master_req [NUM_MASTERS],
  // decoded routes, one cycle after the request
  output route_t                      master_route [NUM_MASTERS],
  // slave selects
  output logic [NUM_CHIP_SEL-1:0]     ext_chip_select_n,
  output logic                        periph_select,
  // map state
  output logic                        remap_active,
  output logic                        boot_from_rom_out,
  output smc_cfg_t                    smc_boot_cfg
);

  // ************************************************************
  // strap capture and remap state
  // ************************************************************

  logic   boot_from_rom;
  logic   next_remap;
  route_t next_route [NUM_MASTERS];

  // strap is frozen at release so the map at zero cannot shift under code
  boot_strap_capture u_strap (
    .clock           (clock),
    .rst_n           (rst_n),
    .boot_source_pin (boot_source_pin),
    .boot_from_rom   (boot_from_rom)
  );

  // set beats clear so a late remap request is never dropped
  always_comb begin
    next_remap = remap_active;
    if (remap_clear) begin
      next_remap = 1'b0;
    end
    if (remap_set) begin
      next_remap = 1'b1;
    end
  end

  // remap flag, cleared by reset
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      remap_active <= 1'b0;
    end else begin
      remap_active <= next_remap;
    end
  end

  // registered copy of the strap for observers
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      boot_from_rom_out <= 1'b1;
    end else begin
      boot_from_rom_out <= boot_from_rom;
    end
  end

  // ************************************************************
  // per-master decoders
  // ************************************************************

  // one decoder per master; only the processor ports get the boot window
  for (genvar m = 0; m < NUM_MASTERS; m++) begin : g_master
    localparam bit CPU_PORT = (m == MASTER_CPU_INSTR) || (m == MASTER_CPU_DATA);

    bank_decoder #(
      .REMAP_CAPABLE (CPU_PORT)
    ) u_decode (
      .req           (master_req[m]),
      .boot_from_rom (boot_from_rom),
      .remap         (remap_active),
      .route         (next_route[m])
    );

    // route register; the abort rides with the answer cycle
    always_ff @(posedge clock) begin
      if (!rst_n) begin
        master_route[m] <= '0;
      end else begin
        master_route[m] <= next_route[m];
      end
    end
  end

  // ************************************************************
  // slave select aggregation
  // ************************************************************

  // chip select n goes low while any master's valid route names it; the
  // external interface arbitrates, this only flags demand
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ext_chip_select_n <= '1;
    end else begin
      ext_chip_select_n <= ~ext_demand(next_route);
    end
  end

  // peripheral bridge select
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      periph_select <= 1'b0;
    end else begin
      periph_select <= periph_demand(next_route);
    end
  end

  // static memory defaults follow the strap; meaningful only for external boot
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      smc_boot_cfg <= '0;
    end else if (!boot_from_rom) begin
      smc_boot_cfg.byte_select  <= BOOT_BYTE_SEL;
      smc_boot_cfg.data_width   <= WIDTH_16;
      smc_boot_cfg.strobe_by_cs <= BOOT_STROBE_CS;
    end else begin
      smc_boot_cfg <= '0;
    end
  end

  // demand on each external chip select over all masters
  function automatic logic [NUM_CHIP_SEL-1:0] ext_demand(input route_t r [NUM_MASTERS]);
    logic [NUM_CHIP_SEL-1:0] d;
    d = '0;
    for (int i = 0; i < NUM_MASTERS; i++) begin
      if (r[i].valid && r[i].slave == SLV_EXT) begin
        d[r[i].chip_sel] = 1'b1;
      end
    end
    return d;
  endfunction : ext_demand

  // any master headed for the peripheral bank
  function automatic logic periph_demand(input route_t r [NUM_MASTERS]);
    logic d;
    d = 1'b0;
    for (int i = 0; i < NUM_MASTERS; i++) begin
      if (r[i].valid && r[i].slave == SLV_PERIPH) begin
        d = 1'b1;
      end
    end
    return d;
  endfunction : periph_demand

  // ************************************************************
  // checks
  // ************************************************************

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  // remap comes up clear from every reset
  chk_remap_reset_clear: assert property (
    $rose(rst_n) |-> !remap_active
  ) else $error("remap not clear after reset");

  // strap level never moves between resets
  // the copy takes the caught level on the first edge after release,
  // so its stability is only judged from the second edge on
  chk_strap_held: assert property (
    $past(rst_n) && $past(rst_n, 2) |-> $stable(boot_from_rom_out)
  ) else $error("boot strap changed outside reset");

  // the caught strap itself, read by every decoder from the first cycle
  chk_strap_frozen: assert property (
    $past(rst_n) |-> $stable(boot_from_rom)
  ) else $error("captured strap moved outside reset");

  // the observer copy trails the caught level by one edge
  chk_strap_copy: assert property (
    $past(rst_n) |-> boot_from_rom_out == $past(boot_from_rom)
  ) else $error("strap copy differs from captured level");

  // set and clear together leave remap set
  chk_remap_set_wins: assert property (
    remap_set |=> remap_active
  ) else $error("remap set lost");

  // external boot defaults, one edge after the caught strap is low
  chk_smc_boot_cfg: assert property (
    !boot_from_rom |=> smc_boot_cfg.byte_select == BOOT_BYTE_SEL
      && smc_boot_cfg.data_width == WIDTH_16 && smc_boot_cfg.strobe_by_cs == BOOT_STROBE_CS
  ) else $error("external boot bus defaults wrong");

  // rom boot leaves the static memory defaults clear
  chk_smc_rom_idle: assert property (
    boot_from_rom |=> smc_boot_cfg == '0
  ) else $error("static memory defaults set on rom boot");

  // a clear without a set drops remap on the next edge
  chk_remap_clear: assert property (
    remap_clear && !remap_set |=> !remap_active
  ) else $error("remap clear lost");

  // with no request remap keeps its level until the next reset
  chk_remap_holds: assert property (
    !remap_set && !remap_clear |=> $stable(remap_active)
  ) else $error("remap changed on its own");

  // with every master idle no select may stay up on the next edge
  chk_idle_selects: assert property (
    !master_req[0].valid && !master_req[1].valid && !master_req[2].valid && !master_req[3].valid
      |=> ext_chip_select_n == '1 && !periph_select
  ) else $error("select raised with no request");

  for (genvar m = 0; m < NUM_MASTERS; m++) begin : g_chk
    localparam bit CPU_PORT = (m == MASTER_CPU_INSTR) || (m == MASTER_CPU_DATA);

    // no answer without a request
    chk_route_needs_req: assert property (
      !master_req[m].valid |=> !master_route[m].valid
    ) else $error("route without request");

    // every request is answered on the next edge
    chk_route_answers: assert property (
      master_req[m].valid |=> master_route[m].valid
    ) else $error("request not answered");

    // slots above the last internal memory abort in bank zero
    chk_unused_slot: assert property (
      master_req[m].valid && master_req[m].addr[31:28] == BANK_INTERNAL
        && master_req[m].addr[27:20] > SLOT_SRAM1
        |=> master_route[m].valid && master_route[m].abort
    ) else $error("unused internal slot did not abort");

    // external banks hand on the low 28 address bits
    chk_ext_offset: assert property (
      master_req[m].valid && master_req[m].addr[31:28] >= BANK_EXT_FIRST
        && master_req[m].addr[31:28] <= BANK_EXT_LAST
        |=> master_route[m].offset == $past(master_req[m].addr[27:0])
    ) else $error("external bank offset wrong");

    // second SRAM at its own base whatever the map at zero
    chk_sram1_base: assert property (
      master_req[m].valid && master_req[m].addr[31:20] == {BANK_INTERNAL, SLOT_SRAM1}
        && master_req[m].addr[19:0] < SRAM_BYTES
        |=> master_route[m].slave == SLV_SRAM1 && !master_route[m].abort
    ) else $error("second sram missing at base address");

    // banks eight to fourteen abort
    chk_unused_bank_abort: assert property (
      master_req[m].valid && master_req[m].addr[31:28] > BANK_EXT_LAST
        && master_req[m].addr[31:28] < BANK_PERIPH
        |=> master_route[m].valid && master_route[m].abort
    ) else $error("unused bank did not abort");

    // external banks carry their chip select number
    chk_ext_bank_cs: assert property (
      master_req[m].valid && master_req[m].addr[31:28] >= BANK_EXT_FIRST
        && master_req[m].addr[31:28] <= BANK_EXT_LAST
        |=> master_route[m].slave == SLV_EXT
        && master_route[m].chip_sel == $past(master_req[m].addr[30:28])
        && !ext_chip_select_n[$past(master_req[m].addr[30:28])]
    ) else $error("external bank chip select wrong");

    // peripheral bank
    chk_periph_bank: assert property (
      master_req[m].valid && master_req[m].addr[31:28] == BANK_PERIPH
        |=> master_route[m].slave == SLV_PERIPH && periph_select
    ) else $error("peripheral bank not routed");

    // ROM at its own base regardless of strap and remap
    chk_rom_base: assert property (
      master_req[m].valid && master_req[m].addr[31:20] == {BANK_INTERNAL, SLOT_ROM}
        && master_req[m].addr[19:0] < ROM_BYTES
        |=> master_route[m].slave == SLV_ROM && !master_route[m].abort
    ) else $error("rom missing at base address");

    if (CPU_PORT) begin : g_cpu
      // remapped SRAM at zero
      chk_remap_zero: assert property (
        master_req[m].valid && remap_active && master_req[m].addr <= BOOT_WINDOW_TOP
          && master_req[m].addr[19:0] < SRAM_BYTES
          |=> master_route[m].slave == SLV_FIRST_INTERNAL_SRAM
      ) else $error("remapped sram not at zero");

      // strap high: ROM at zero
      chk_boot_rom: assert property (
        master_req[m].valid && !remap_active && boot_from_rom
          && master_req[m].addr < {12'h000, ROM_BYTES}
          |=> master_route[m].slave == SLV_ROM
      ) else $error("rom not at zero");

      // strap low: whole first megabyte to chip select zero
      chk_boot_ext: assert property (
        master_req[m].valid && !remap_active && !boot_from_rom
          && master_req[m].addr <= BOOT_WINDOW_TOP
          |=> master_route[m].slave == SLV_EXT && master_route[m].chip_sel == 3'h0
          && !ext_chip_select_n[0]
      ) else $error("external boot not at zero");

      // remapped window beyond the 4K SRAM aborts
      chk_remap_tail: assert property (
        master_req[m].valid && remap_active && master_req[m].addr <= BOOT_WINDOW_TOP
          && master_req[m].addr[19:0] >= SRAM_BYTES
          |=> master_route[m].abort
      ) else $error("remapped window tail did not abort");

      // rom boot window beyond the ROM aborts; no mirroring
      chk_rom_tail: assert property (
        master_req[m].valid && !remap_active && boot_from_rom && master_req[m].addr <= BOOT_WINDOW_TOP
          && master_req[m].addr[19:0] >= ROM_BYTES
          |=> master_route[m].abort
      ) else $error("rom window tail did not abort");
    end else begin : g_other
      // other masters see no boot memory at zero
      chk_no_boot_window: assert property (
        master_req[m].valid && master_req[m].addr <= BOOT_WINDOW_TOP
          |=> master_route[m].valid && master_route[m].abort
      ) else $error("boot window open to a non-processor master");
    end
  end

endmodule : boot_remap_address_decoder

// file: dv/bus_master_model.sv
// bus master model: every master presents one address in the same cycle
// assumes the bench calls its tasks at the falling edge of clock
`timescale 1ns/1ps
module bus_master_model
  import remap_pkg::*;
(
  // clock
  input  wire logic clock,
  // requests toward the decoder
  output bus_req_t  master_req [NUM_MASTERS]
);
  // ************************************************************
  // request driving
  // ************************************************************
  // idle masters from time zero
  initial begin
    for (int m = 0; m < NUM_MASTERS; m++) begin
      master_req[m] = '0;
    end
  end

  // same address on all masters; write bit varies since decode ignores it
  task automatic drive_all(input logic [31:0] addr, input logic wr);
    for (int m = 0; m < NUM_MASTERS; m++) begin
      master_req[m] = '{valid: 1'b1, write: wr ^ m[0], addr: addr};
    end
  endtask : drive_all

  // released address shows its inverse so a stale value never decodes
  task automatic release_all();
    for (int m = 0; m < NUM_MASTERS; m++) begin
      master_req[m].valid = 1'b0;
      master_req[m].addr  = ~master_req[m].addr;
    end
  endtask : release_all
endmodule : bus_master_model

// file: dv/testbench.sv
// self-checking bench for the boot-remap address decoder
// assumes the bus master model drives requests; bench drives strap and remap
`timescale 1ns/1ps
module testbench;
  import remap_pkg::*;
  // ************************************************************
  // signals
  // ************************************************************
  logic                    clock;
  logic                    rst_n;
  logic                    boot_source_pin;
  logic                    remap_set;
  logic                    remap_clear;
  bus_req_t                master_req [NUM_MASTERS];
  route_t                  master_route [NUM_MASTERS];
  logic [NUM_CHIP_SEL-1:0] ext_chip_select_n;
  logic                    periph_select;
  logic                    remap_active;
  logic                    boot_from_rom_out;
  smc_cfg_t                smc_boot_cfg;
  int                      fails;
  int                      checks;
  logic                    rmp;
  logic                    rom;

  // clock at 4 ns period, inputs idle from time zero
  initial begin
    clock = 1'b0;
    rst_n = 1'b0;
    boot_source_pin = 1'b1;
    remap_set = 1'b0;
    remap_clear = 1'b0;
    fails = 0;
    checks = 0;
  end
  always #2 clock = ~clock;

  boot_remap_address_decoder boot_remap_address_decoder_i (
    .clock(clock), .rst_n(rst_n), .boot_source_pin(boot_source_pin), .remap_set(remap_set),
    .remap_clear(remap_clear), .master_req(master_req), .master_route(master_route),
    .ext_chip_select_n(ext_chip_select_n), .periph_select(periph_select), .remap_active(remap_active),
    .boot_from_rom_out(boot_from_rom_out), .smc_boot_cfg(smc_boot_cfg));

  bus_master_model bus_master_model_i (.clock(clock), .master_req(master_req));

  // ************************************************************
  // helpers
  // ************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  // expected route from the map; other masters see no boot window
  function automatic route_t expect_route(int m, logic [31:0] a);
    route_t r;
    r = '0;
    r.valid = 1'b1;
    r.slave = SLV_NONE;
    r.offset = {8'h00, a[19:0]};
    if (a[31:28] == 4'h0) begin
      if (a[27:20] == 8'h00 && m < 2) begin
        if (rmp) r.slave = (a[19:0] < 20'h01000) ? SLV_FIRST_INTERNAL_SRAM : SLV_NONE;
        else if (rom) r.slave = (a[19:0] < 20'h08000) ? SLV_ROM : SLV_NONE;
        else r.slave = SLV_EXT;
      end
      if (a[27:20] == 8'h01 && a[19:0] < 20'h08000) r.slave = SLV_ROM;
      if (a[27:20] == 8'h02 && a[19:0] < 20'h01000) r.slave = SLV_FIRST_INTERNAL_SRAM;
      if (a[27:20] == 8'h03 && a[19:0] < 20'h01000) r.slave = SLV_SRAM1;
    end else if (a[31:28] <= 4'h7) begin
      r.slave = SLV_EXT;
    end else if (a[31:28] == 4'hF) begin
      r.slave = SLV_PERIPH;
    end
    if (r.slave == SLV_EXT) begin
      r.chip_sel = a[30:28];
      r.offset = a[27:0];
    end
    if (r.slave == SLV_PERIPH) r.offset = a[27:0];
    r.abort = (r.slave == SLV_NONE);
    return r;
  endfunction : expect_route

  // one request on every master, judged one cycle later
  task automatic access(input logic [31:0] a);
    route_t                  e;
    logic [NUM_CHIP_SEL-1:0] cs;
    logic                    ps;
    cs = '1;
    ps = 1'b0;
    bus_master_model_i.drive_all(a, a[2]);
    @(negedge clock);
    for (int m = 0; m < NUM_MASTERS; m++) begin
      e = expect_route(m, a);
      check({master_route[m].valid, master_route[m].abort, master_route[m].slave}, {e.valid, e.abort, e.slave}, "route");
      if (e.slave == SLV_EXT) begin
        check(master_route[m].chip_sel, e.chip_sel, "chip select");
        cs[e.chip_sel] = 1'b0;
      end
      if (e.slave != SLV_NONE) begin
        check(master_route[m].offset, e.offset, "offset");
      end
      ps = ps | (e.slave == SLV_PERIPH);
    end
    check(ext_chip_select_n, cs, "chip select lines");
    check(periph_select, ps, "peripheral select");
  endtask : access

  task automatic do_reset(input logic pin);
    @(negedge clock);
    rst_n = 1'b0;
    boot_source_pin = pin;
    remap_set = 1'b0;
    remap_clear = 1'b0;
    bus_master_model_i.release_all();
    repeat (6) @(negedge clock);
    rst_n = 1'b1;
    rmp = 1'b0;
    rom = pin;
  endtask : do_reset

  task automatic pulse_remap(input logic s, input logic c);
    remap_set = s;
    remap_clear = c;
    @(negedge clock);
    remap_set = 1'b0;
    remap_clear = 1'b0;
    rmp = s ? 1'b1 : (c ? 1'b0 : rmp);
    check(remap_active, rmp, "remap state");
  endtask : pulse_remap

  task automatic end_sim();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim

  // ************************************************************
  // scenarios
  // ************************************************************
  // strap low: external boot window, strap held when the pin moves
  task automatic test_ext_boot();
    do_reset(1'b0);
    access(32'h0000_0000);
    check(boot_from_rom_out, 1'b0, "strap copy");
    check(smc_boot_cfg, {BOOT_BYTE_SEL, WIDTH_16, BOOT_STROBE_CS}, "boot static config");
    boot_source_pin = 1'b1;
    repeat (4) @(negedge clock);
    access(32'h000F_FFFC);
    check(boot_from_rom_out, 1'b0, "strap held");
    pulse_remap(1'b1, 1'b0);
    access(32'h0000_0000);
    $display("external boot test done");
  endtask : test_ext_boot

  // strap high: whole map walk, reset clears remap
  task automatic test_rom_boot();
    logic [31:0] tbl [10];
    tbl = '{32'h0000_7FFC, 32'h0000_8000, 32'h000F_FFFC, 32'h0010_0000, 32'h0010_8000,
            32'h0020_0FFC, 32'h0020_1000, 32'h0030_0004, 32'h0040_0000, 32'hFFFF_F000};
    do_reset(1'b1);
    access(32'h0000_0000);
    check(remap_active, 1'b0, "remap after reset");
    check(smc_boot_cfg, 4'h0, "rom boot static config");
    check(boot_from_rom_out, 1'b1, "strap copy high");
    for (int b = 1; b < 16; b++) begin
      access({b[3:0], 28'h00000A4});
    end
    for (int i = 0; i < 10; i++) begin
      access(tbl[i]);
    end
    bus_master_model_i.release_all();
    @(negedge clock);
    check(master_route[0].valid, 1'b0, "idle route");
    check(ext_chip_select_n, 8'hFF, "idle chip selects");
    check(periph_select, 1'b0, "idle peripheral select");
    $display("rom boot test done");
  endtask : test_rom_boot

  // remap set, set against clear, clear
  task automatic test_remap();
    pulse_remap(1'b1, 1'b0);
    access(32'h0000_0FFC);
    access(32'h0000_1000);
    access(32'h0010_0000);
    access(32'h0020_0000);
    pulse_remap(1'b0, 1'b1);
    pulse_remap(1'b1, 1'b1);
    pulse_remap(1'b0, 1'b1);
    access(32'h0000_0000);
    $display("remap test done");
  endtask : test_remap

  // ************************************************************
  // main sequence and watchdog
  // ************************************************************
  initial begin
    rmp = 1'b0;
    rom = 1'b1;
    repeat (6) @(negedge clock);
    test_ext_boot();
    test_rom_boot();
    test_remap();
    end_sim();
  end

  // the whole run needs under seventy cycles; this leaves wide margin
  initial begin
    #20000;
    fails++;
    $display("Error at %0t: watchdog expired", $time);
    end_sim();
  end
endmodule : testbench
